// ---- rtl/fph_pkg.sv ----
// Package of constants and types for the flash protection and pause block.
package fph_pkg;
  // Wishbone register byte addresses.
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_LOCK = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_TARGET = 8'h0C;
  localparam logic [7:0] ADDR_LINK = 8'h10;
  // Status register field positions.
  localparam int SR_BUSY = 0;
  localparam int SR_LATCH = 1;
  localparam int SR_LVL_LSB = 2;
  localparam int SR_LOW = 5;
  localparam int SR_SWL = 7;
  localparam logic [7:0] SR_WR_MASK = 8'hBC;
  // Command field layout.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  // Link status field layout.
  localparam int LK_ACCEPT = 0;
  localparam int LK_REFUSE = 1;
  localparam int LK_PAUSED = 2;
  localparam int LK_SELECTED = 3;
  localparam int LK_BITS_LSB = 4;
  localparam int LK_RXB_LSB = 8;
  // Array geometry.
  localparam int ADDR_W = 21;
  localparam int SECT_N = 32;
  localparam int SECT_W = 5;
  localparam int SUBS_W = 12;
  localparam int SECT_OFS_W = 16;
  localparam int PAGE_W = 8;
  localparam int ARRAY_BYTES = 2097152;
  localparam int SUBSECT_N = 512;
  localparam int PAGE_N = 8192;
  localparam int OTP_BYTES = 64;
  localparam logic [20:0] ADDR_TOP = 21'h1FFFFF;
  localparam logic [20:0] SUBS_MASK = 21'h1FF000;
  localparam logic [20:0] SECT_MASK = 21'h1F0000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [2:0] LVL_NONE = 3'h0;
  localparam logic [2:0] LVL_ALL = 3'h6;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Internal cycle length minus one, in system clock cycles.
  localparam logic [15:0] BUSY_CYCLES = 16'h0040;
  // Array span encodings.
  localparam logic [1:0] SPAN_BYTE = 2'h0;
  localparam logic [1:0] SPAN_SUBS = 2'h1;
  localparam logic [1:0] SPAN_SECT = 2'h2;
  localparam logic [1:0] SPAN_ALL = 2'h3;
  // Operation codes written to the command register.
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_WREN = 3'b001, OP_WRDI = 3'b010, OP_PROG = 3'b011,
    OP_SSE = 3'b100, OP_SE = 3'b101, OP_BE = 3'b110, OP_RSV = 3'b111
  } fph_op_t;
  // Internal cycle states.
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00, CYC_STAT = 2'b01, CYC_ARRAY = 2'b10
  } fph_cyc_t;
  // Serial link states.
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00, LINK_ACTIVE = 2'b01, LINK_PAUSED = 2'b10
  } fph_link_t;
endpackage

// ---- rtl/fph_top.sv ----
// Write protection, sector range decode and serial pause logic of a serial flash.
//
// Contract
// [R1] Write-protect pin freezes status register.
// [R2] Whole-array erase only with protect level zero.
// [R3] Low bit 0: codes 1-5 protect top sectors.
// [R4] Low bit 1: codes 1-5 protect bottom sectors.
// [R5] Codes 6 and 7 protect all 32 sectors.
// [R6] Pause keeps current bit position.
// [R7] Pause never aborts a running internal cycle.
// [R8] Master selects device before pausing.
// [R9] Pause starts when clock low after falling pause.
// [R10] Pause ends when clock low after rising pause.
// [R11] Paused: output floats, input and clock ignored.
// [R12] Paused and selected: interface state kept.
// [R13] Deselect while paused resets interface logic.
// [R14] Master releases pause before reselecting.
// [R15] Program only clears bits within a page.
// [R16] Erase sets bits; subsector, sector or all.
// [R17] Array is 2,097,152 bytes, 32 sectors.
// [R18] 512 subsectors of 4KB.
// [R19] 8,192 aligned pages of 256 bytes.
// [R20] 64 one-time bytes outside main array.
// [R21] Sector and subsector address ranges are aligned.
// [R22] Sector lock bit makes modifications fail.
// [R23] Modifying commands need write latch set.
// [R24] Protected target discarded, no internal cycle.
// [R25] Decoder compares upper five address bits.
`timescale 1ns/10ps
`default_nettype none
module fph_top (
  input wire logic clk_sys_in, // System clock, 50 MHz.
  input wire logic rst_n_in, // Asynchronous active-low reset.
  input wire logic wb_cyc_in, // Wishbone cycle.
  input wire logic wb_stb_in, // Wishbone strobe.
  input wire logic wb_we_in, // Wishbone write enable.
  input wire logic [7:0] wb_adr_in, // Wishbone byte address.
  input wire logic [3:0] wb_sel_in, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_in, // Wishbone write data.
  output logic [31:0] wb_dat_out, // Wishbone read data.
  output logic wb_ack_out, // Wishbone acknowledge.
  input wire logic select_n_in, // Serial select pin, active low.
  input wire logic sclk_in, // Serial clock pin.
  input wire logic serial_in, // Serial data input pin.
  input wire logic pause_n_in, // Pause pin, active low.
  input wire logic write_protect_n_in, // Write-protect pin, active low.
  output logic serial_out, // Serial data output.
  output logic serial_out_oe_out, // Output enable for serial_out.
  input wire logic [7:0] arr_rdata_in, // Current array byte at arr_addr_out.
  output logic arr_start_out, // One-cycle start of an array cycle.
  output logic [1:0] arr_span_out, // Span of the array cycle.
  output logic [20:0] arr_addr_out, // Aligned array address.
  output logic [7:0] arr_wdata_out // Byte to store for a program.
);

  // ************************************************************
  // Reset release and pin synchronisers
  // ************************************************************

  logic rst_s1_r;
  logic rst_n_r;
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic sclk_prev_r;

  // Reset is released through two flip-flops.
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Each pin passes two flip-flops before any logic reads it.
  always_ff @(posedge clk_sys_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pin_s1_r <= 5'h19;
      pin_s2_r <= 5'h19;
      sclk_prev_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= {write_protect_n_in, pause_n_in, serial_in, sclk_in, select_n_in};
      pin_s2_r <= pin_s1_r;
      sclk_prev_r <= pin_s2_r[1];
    end
  end

  logic sel_n;
  logic sclk;
  logic sin;
  logic pause_n;
  logic wp_on;
  logic sclk_rise;
  logic sclk_fall;
  // Synchronised pin views and clock edges.
  assign sel_n = pin_s2_r[0];
  assign sclk = pin_s2_r[1];
  assign sin = pin_s2_r[2];
  assign pause_n = pin_s2_r[3];
  assign wp_on = !pin_s2_r[4];
  assign sclk_rise = sclk && !sclk_prev_r;
  assign sclk_fall = !sclk && sclk_prev_r;

  // ************************************************************
  // Protected range decode
  // ************************************************************

  // True when the sector lies in the range chosen by level and low bit.
  function automatic logic prot_hit(input logic [4:0] sect, input logic [2:0] lvl,
                                    input logic low);
    logic [5:0] span;
    span = 6'h0;
    if (lvl >= fph_pkg::LVL_ALL)
      prot_hit = 1'b1; // [R5]
    else if (lvl == fph_pkg::LVL_NONE)
      prot_hit = 1'b0;
    else
    begin
      span = 6'h1 << (lvl - 3'h1);
      if (low)
        prot_hit = {1'b0, sect} < span; // [R4]
      else
        prot_hit = {1'b0, sect} >= (6'h20 - span); // [R3]
    end
  endfunction

  // ************************************************************
  // Status, lock and command registers
  // ************************************************************

  logic [2:0] protect_level_r;
  logic protect_low_r;
  logic status_write_lock_r;
  logic write_latch_r;
  logic [31:0] sector_lock_r;
  logic [20:0] target_r;
  logic accept_r;
  logic refuse_r;
  fph_pkg::fph_cyc_t cyc_r;
  logic [15:0] busy_cnt_r;
  logic busy;
  logic wb_req;
  logic wr_status;
  logic wr_cmd;
  logic sr_ok;
  fph_pkg::fph_op_t op;
  logic [7:0] prog_byte;
  logic [4:0] tgt_sect;
  logic modify;
  logic blocked;
  logic go;
  logic [7:0] status_byte;

  assign busy = (cyc_r != fph_pkg::CYC_IDLE);
  assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_status = wb_req && wb_we_in && wb_sel_in[0] && (wb_adr_in == fph_pkg::ADDR_STATUS);
  assign wr_cmd = wb_req && wb_we_in && wb_sel_in[0] && (wb_adr_in == fph_pkg::ADDR_CMD);
  // Status write needs latch, idle array and the protect pin released.
  assign sr_ok = wr_status && write_latch_r && !busy && !wp_on; // [R1] [R23]
  assign op = fph_pkg::fph_op_t'(wb_dat_in[fph_pkg::CMD_OP_LSB +: 3]);
  assign prog_byte = wb_dat_in[fph_pkg::CMD_DATA_LSB +: 8];
  assign tgt_sect = target_r[fph_pkg::ADDR_W-1 -: fph_pkg::SECT_W]; // [R25] [R21]
  assign modify = (op == fph_pkg::OP_PROG) || (op == fph_pkg::OP_SSE) ||
                  (op == fph_pkg::OP_SE) || (op == fph_pkg::OP_BE);
  // Refusal reasons for a modifying command.
  always_comb
  begin
    blocked = busy || !write_latch_r; // [R23]
    if (op == fph_pkg::OP_BE)
      blocked = blocked || (protect_level_r != fph_pkg::LVL_NONE) ||
                (sector_lock_r != 32'h0); // [R2] [R22]
    else
      blocked = blocked || prot_hit(tgt_sect, protect_level_r, protect_low_r) ||
                sector_lock_r[tgt_sect]; // [R24] [R22]
  end
  assign go = wr_cmd && modify && !blocked;
  assign status_byte = {status_write_lock_r, 1'b0, protect_low_r, protect_level_r,
                        write_latch_r, busy};

  // Status bits and write latch.
  always_ff @(posedge clk_sys_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      protect_level_r <= 3'h0;
      protect_low_r <= 1'b0;
      status_write_lock_r <= 1'b0;
      write_latch_r <= 1'b0;
    end
    else
    begin
      if (sr_ok)
      begin
        protect_level_r <= wb_dat_in[fph_pkg::SR_LVL_LSB +: 3]; // [R1]
        protect_low_r <= wb_dat_in[fph_pkg::SR_LOW];
        status_write_lock_r <= wb_dat_in[fph_pkg::SR_SWL];
      end
      if (wr_cmd && (op == fph_pkg::OP_WREN) && !busy)
        write_latch_r <= 1'b1;
      else if ((wr_cmd && (op == fph_pkg::OP_WRDI) && !busy) ||
               (busy && (busy_cnt_r == 16'h0)))
        write_latch_r <= 1'b0;
    end
  end

  // Sector locks, target address and result flags.
  always_ff @(posedge clk_sys_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      sector_lock_r <= 32'h0;
      target_r <= 21'h0;
      accept_r <= 1'b0;
      refuse_r <= 1'b0;
    end
    else
    begin
      if (wb_req && wb_we_in && (wb_adr_in == fph_pkg::ADDR_LOCK))
        for (int b = 0; b < 4; b++)
          if (wb_sel_in[b])
            sector_lock_r[b*8 +: 8] <= wb_dat_in[b*8 +: 8]; // [R22]
      // The upper lane keeps only the sector bits, so no target leaves the main array.
      if (wb_req && wb_we_in && (wb_adr_in == fph_pkg::ADDR_TARGET))
      begin
        for (int b = 0; b < 2; b++)
          if (wb_sel_in[b])
            target_r[b*8 +: 8] <= wb_dat_in[b*8 +: 8];
        if (wb_sel_in[2])
          target_r[fph_pkg::ADDR_W-1:fph_pkg::SECT_OFS_W] <=
            wb_dat_in[fph_pkg::ADDR_W-1:fph_pkg::SECT_OFS_W]; // [R17] [R20]
      end
      if (wr_cmd && modify)
      begin
        accept_r <= !blocked;
        refuse_r <= blocked;
      end
    end
  end

  // ************************************************************
  // Internal cycle and array requests
  // ************************************************************

  // The cycle counts on the system clock and never looks at pause.
  always_ff @(posedge clk_sys_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cyc_r <= fph_pkg::CYC_IDLE;
      busy_cnt_r <= 16'h0;
    end
    else
    begin
      case (cyc_r)
        fph_pkg::CYC_IDLE:
        begin
          busy_cnt_r <= fph_pkg::BUSY_CYCLES;
          if (sr_ok)
            cyc_r <= fph_pkg::CYC_STAT;
          else if (go)
            cyc_r <= fph_pkg::CYC_ARRAY;
        end
        fph_pkg::CYC_STAT, fph_pkg::CYC_ARRAY:
        begin
          busy_cnt_r <= busy_cnt_r - 16'h1; // [R7]
          if (busy_cnt_r == 16'h0)
            cyc_r <= fph_pkg::CYC_IDLE;
        end
        default:
          cyc_r <= fph_pkg::CYC_IDLE;
      endcase
    end
  end

  // Array request: program clears bits, erase sets them over an aligned span.
  always_ff @(posedge clk_sys_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      arr_start_out <= 1'b0;
      arr_span_out <= fph_pkg::SPAN_BYTE;
      arr_addr_out <= 21'h0;
      arr_wdata_out <= fph_pkg::ERASED_BYTE;
    end
    else
    begin
      arr_start_out <= go; // [R24]
      if (go)
      begin
        case (op)
          fph_pkg::OP_PROG:
          begin
            arr_span_out <= fph_pkg::SPAN_BYTE; // [R15] [R19]
            arr_addr_out <= target_r;
            arr_wdata_out <= arr_rdata_in & prog_byte; // [R15]
          end
          fph_pkg::OP_SSE:
          begin
            arr_span_out <= fph_pkg::SPAN_SUBS; // [R16] [R18]
            arr_addr_out <= target_r & fph_pkg::SUBS_MASK; // [R21]
            arr_wdata_out <= fph_pkg::ERASED_BYTE;
          end
          fph_pkg::OP_SE:
          begin
            arr_span_out <= fph_pkg::SPAN_SECT; // [R16] [R17]
            arr_addr_out <= target_r & fph_pkg::SECT_MASK; // [R21]
            arr_wdata_out <= fph_pkg::ERASED_BYTE;
          end
          default:
          begin
            arr_span_out <= fph_pkg::SPAN_ALL; // [R16]
            arr_addr_out <= 21'h0;
            arr_wdata_out <= fph_pkg::ERASED_BYTE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Serial link with pause
  // ************************************************************

  fph_pkg::fph_link_t link_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_shift_r;
  logic [7:0] rx_byte_r;
  logic paused;
  logic live;

  assign paused = (link_r == fph_pkg::LINK_PAUSED);
  assign live = (link_r == fph_pkg::LINK_ACTIVE);

  // Link state: pause is entered, and released back to active, only while the clock is low; deselect leaves it at once.
  always_ff @(posedge clk_sys_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
      link_r <= fph_pkg::LINK_IDLE;
    else
    begin
      case (link_r)
        fph_pkg::LINK_IDLE:
          if (!sel_n && pause_n)
            link_r <= fph_pkg::LINK_ACTIVE; // [R14]
        fph_pkg::LINK_ACTIVE:
          if (sel_n)
            link_r <= fph_pkg::LINK_IDLE;
          else if (!pause_n && !sclk)
            link_r <= fph_pkg::LINK_PAUSED; // [R9] [R8]
        fph_pkg::LINK_PAUSED:
          if (sel_n)
            link_r <= fph_pkg::LINK_IDLE; // [R13]
          else if (pause_n && !sclk)
            link_r <= fph_pkg::LINK_ACTIVE; // [R10]
        default:
          link_r <= fph_pkg::LINK_IDLE;
      endcase
    end
  end

  // Bit shifting runs only while active; pausing freezes it in place.
  always_ff @(posedge clk_sys_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      bit_cnt_r <= 3'h0;
      rx_shift_r <= 8'h0;
      rx_byte_r <= 8'h0;
      serial_out <= 1'b0;
    end
    else if (link_r == fph_pkg::LINK_IDLE)
    begin
      bit_cnt_r <= 3'h0; // [R13]
      rx_shift_r <= 8'h0;
      serial_out <= status_byte[fph_pkg::BIT_LAST];
    end
    else if (live)
    begin
      if (sclk_rise)
      begin
        rx_shift_r <= {rx_shift_r[6:0], sin}; // [R6] [R11] [R12]
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == fph_pkg::BIT_LAST)
          rx_byte_r <= {rx_shift_r[6:0], sin};
      end
      if (sclk_fall)
        serial_out <= status_byte[fph_pkg::BIT_LAST - bit_cnt_r];
    end
  end

  // Output floats while paused or deselected.
  assign serial_out_oe_out = live; // [R11]

  // ************************************************************
  // Wishbone answer
  // ************************************************************

  // One wait state: ack and read data one edge after the request.
  always_ff @(posedge clk_sys_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end
    else
    begin
      wb_ack_out <= wb_req;
      if (wb_req && !wb_we_in)
      begin
        case (wb_adr_in)
          fph_pkg::ADDR_STATUS: wb_dat_out <= {24'h0, status_byte};
          fph_pkg::ADDR_LOCK: wb_dat_out <= sector_lock_r;
          fph_pkg::ADDR_TARGET: wb_dat_out <= {11'h0, target_r};
          fph_pkg::ADDR_LINK: wb_dat_out <= {16'h0, rx_byte_r, 1'b0, bit_cnt_r,
                                            !sel_n, paused, refuse_r, accept_r};
          default: wb_dat_out <= 32'h0;
        endcase
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************

  a_wp_freeze: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R1]
    wp_on && $stable(wp_on) |=> $stable(protect_level_r) && $stable(status_write_lock_r))
    else $error("Status bits changed while write protect held.");
  a_bulk_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R2]
    arr_start_out && arr_span_out == fph_pkg::SPAN_ALL |-> $past(protect_level_r) == 3'h0)
    else $error("Bulk erase started with nonzero protect level.");
  a_top_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R3]
    go && op == fph_pkg::OP_SE && !protect_low_r && protect_level_r == 3'h5
    |-> tgt_sect < 5'h10)
    else $error("Erase allowed in protected upper half.");
  a_low_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R4]
    go && op != fph_pkg::OP_BE && protect_low_r && protect_level_r == 3'h1
    |-> tgt_sect != 5'h0)
    else $error("Modification allowed in protected sector zero.");
  a_all_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R5]
    protect_level_r >= 3'h6 |-> !go)
    else $error("Array cycle started with all sectors protected.");
  a_pause_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R12]
    paused && $past(paused) |-> $stable(bit_cnt_r) && $stable(rx_shift_r))
    else $error("Interface state moved during pause.");
  a_pause_entry: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R9]
    live && !sel_n && !pause_n && !sclk |=> paused)
    else $error("Pause not entered with clock low.");
  a_pause_float: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R11]
    paused |-> !serial_out_oe_out)
    else $error("Output driven during pause.");
  a_busy_runs: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R7]
    busy && busy_cnt_r != 16'h0 |=> busy && busy_cnt_r == $past(busy_cnt_r) - 16'h1)
    else $error("Internal cycle stalled or aborted.");
  a_latch_need: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R23]
    arr_start_out |-> $past(write_latch_r))
    else $error("Array cycle without write latch.");
  a_deselect_rst: assert property (@(posedge clk_sys_in) disable iff (!rst_n_r) // [R13]
    paused && sel_n |=> link_r == fph_pkg::LINK_IDLE ##1 bit_cnt_r == 3'h0)
    else $error("Deselect in pause did not reset interface.");
  c_pause_resume: cover property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    paused ##1 live);
  c_refused: cover property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    wr_cmd && modify && blocked);
  c_erase: cover property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    arr_start_out && arr_span_out == fph_pkg::SPAN_SECT);
  c_pause_busy: cover property (@(posedge clk_sys_in) disable iff (!rst_n_r)
    paused && busy);

endmodule // fph_top
`default_nettype wire

// ---- dv/fph_spi_master.sv ----
// Model of the serial bus master that drives select, clock, data and pause pins.
`timescale 1ns/10ps
`default_nettype none
module fph_spi_master (
  input wire logic clk_in, // Bench clock that paces the link.
  output logic select_n_out = 1'b1, // Select, active low.
  output logic sclk_out = 1'b0, // Serial clock, 160 ns period inside frames only.
  output logic sdo_out = 1'b0, // Data toward the device.
  output logic pause_n_out = 1'b1 // Pause, active low.
);
  // Waits a number of bench clock edges.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Sends one byte MSB first; pauses before bit pb and may deselect while paused.
  task automatic xfer(input logic [7:0] b, input int pb, input bit drop);
    select_n_out <= 1'b0;
    tick(6);
    for (int i = 7; i >= 0; i--)
    begin
      if (i == pb)
      begin
        pause_n_out <= 1'b0;
        tick(6);
        // Clock and data wiggle while paused and must be ignored.
        repeat (2)
        begin
          sclk_out <= 1'b1;
          sdo_out <= ~sdo_out;
          tick(4);
          sclk_out <= 1'b0;
          tick(4);
        end
        if (drop)
        begin
          select_n_out <= 1'b1;
          tick(6);
          pause_n_out <= 1'b1;
          tick(6);
          return;
        end
        pause_n_out <= 1'b1;
        tick(6);
      end
      sdo_out <= b[i];
      tick(4);
      sclk_out <= 1'b1;
      tick(4);
      sclk_out <= 1'b0;
    end
    tick(4);
    select_n_out <= 1'b1;
    sdo_out <= ~b[0]; // A released line shows the inverse of the last bit.
    tick(6);
  endtask
endmodule // fph_spi_master
`default_nettype wire

// ---- dv/fph_top_tb.sv ----
// Self-checking bench for the flash protection and pause block.
`timescale 1ns/10ps
`default_nettype none
module fph_top_tb;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, wp_n = 1'b1;
  logic [7:0] adr = 8'h0, rdat = 8'h0, b, c_wd;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0, q, rq;
  logic ack, so, oe, ast, sn, sck, sdi, pn;
  logic [1:0] span, c_span;
  logic [20:0] aa, c_addr;
  logic [7:0] wdo, rxo;
  int fail_count = 0, n_tests = 0, starts = 0, s0 = 0, seed = 32'hA687;
  int sl[4] = '{0, 15, 16, 31};
  // Clock generation.
  always #10 clk = ~clk;
  fph_top fph_top_i (.clk_sys_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rq),
    .wb_ack_out(ack), .select_n_in(sn), .sclk_in(sck), .serial_in(sdi), .pause_n_in(pn),
    .write_protect_n_in(wp_n), .serial_out(so), .serial_out_oe_out(oe), .arr_rdata_in(rdat),
    .arr_start_out(ast), .arr_span_out(span), .arr_addr_out(aa), .arr_wdata_out(wdo));
  fph_spi_master fph_spi_master_i (.clk_in(clk), .select_n_out(sn), .sclk_out(sck),
    .sdo_out(sdi), .pause_n_out(pn));
  // Captures every array cycle start with its span, address and data.
  always @(posedge clk)
  begin
    if (ast === 1'b1)
    begin
      starts++;
      c_span = span;
      c_addr = aa;
      c_wd = wdo;
    end
  end
  // Collects what the device shifts out at each serial clock rise while it drives.
  always @(posedge sck)
  begin
    if (oe === 1'b1)
      rxo <= {rxo[6:0], so};
  end
  // Counts one comparison and reports a mismatch.
  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok)
    begin
      fail_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // One classic Wishbone cycle; released only after ack is sampled.
  task automatic wb(input bit w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rq;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Polls the busy flag until the internal cycle is over.
  task automatic wait_idle;
    do wb(0, fph_pkg::ADDR_STATUS, 32'h0, q); while (q[fph_pkg::SR_BUSY] !== 1'b0);
  endtask
  // Range model: which sectors a low bit and level protect.
  function automatic bit prot(input bit lo, input int lv, input int s);
    int n;
    if (lv == 0) return 1'b0;
    if (lv > 5) return 1'b1;
    n = 1 << (lv - 1);
    return lo ? (s < n) : (s >= 32 - n);
  endfunction
  // Issues one program or erase and compares the outcome with the model.
  task automatic run_op(input logic [2:0] op, input logic [20:0] t, input bit ok, input bit en);
    int c0;
    logic [20:0] ea;
    logic [7:0] nd;
    nd = 8'($random(seed));
    rdat <= 8'($random(seed));
    ea = (op == fph_pkg::OP_PROG) ? t : (op == fph_pkg::OP_SSE) ? (t & fph_pkg::SUBS_MASK) :
         (t & fph_pkg::SECT_MASK);
    wb(1, fph_pkg::ADDR_TARGET, {11'h0, t}, q);
    wb(1, fph_pkg::ADDR_CMD, {29'h0, en ? fph_pkg::OP_WREN : fph_pkg::OP_WRDI}, q);
    c0 = starts;
    wb(1, fph_pkg::ADDR_CMD, {16'h0, nd, 5'h0, op}, q);
    wait_idle();
    chk(starts - c0 == int'(ok), "array cycle start");
    if (ok)
    begin
      chk(c_span === 2'(op - 3'h3), "span");
      chk(op == fph_pkg::OP_BE || c_addr === ea, "address");
      chk(c_wd === ((op == fph_pkg::OP_PROG) ? (rdat & nd) : 8'hFF), "write data");
    end
  endtask
  // Writes the low bit and level, then reads them back.
  task automatic set_prot(input bit lo, input logic [2:0] lv);
    wb(1, fph_pkg::ADDR_CMD, {29'h0, fph_pkg::OP_WREN}, q);
    wb(1, fph_pkg::ADDR_STATUS, {26'h0, lo, lv, 2'h0}, q);
    wait_idle();
    chk(q[5:1] === {lo, lv, 1'b0}, "status readback");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog against a hang.
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    wb(0, 8'h40, 32'h0, q);
    chk(q === 32'h0, "unmapped read");
    for (int lo = 0; lo < 2; lo++)
      for (int lv = 0; lv < 8; lv++)
      begin
        set_prot(lo[0], lv[2:0]);
        foreach (sl[k])
          run_op((k % 2) ? fph_pkg::OP_SE : fph_pkg::OP_SSE, {5'(sl[k]), 16'($random(seed))},
                 !prot(lo[0], lv, sl[k]), 1'b1);
        run_op(fph_pkg::OP_BE, 21'h0, lv == 0, 1'b1);
      end
    $display("Protection table test done");
    set_prot(1'b0, 3'h0);
    run_op(fph_pkg::OP_PROG, 21'($random(seed)), 1'b1, 1'b1);
    wb(1, fph_pkg::ADDR_LOCK, 32'h200, q);
    run_op(fph_pkg::OP_SE, {5'h09, 16'($random(seed))}, 1'b0, 1'b1);
    run_op(fph_pkg::OP_BE, 21'h0, 1'b0, 1'b1);
    wb(1, fph_pkg::ADDR_LOCK, 32'h0, q);
    run_op(fph_pkg::OP_SE, {5'h09, 16'h0}, 1'b0, 1'b0);
    $display("Lock and latch test done");
    wp_n <= 1'b0;
    wb(1, fph_pkg::ADDR_CMD, {29'h0, fph_pkg::OP_WREN}, q);
    wb(1, fph_pkg::ADDR_STATUS, 32'hB4, q);
    wait_idle();
    chk(q[7:2] === 6'h0, "frozen status");
    wp_n <= 1'b1;
    $display("Write protect test done");
    b = 8'($random(seed));
    fork
      fph_spi_master_i.xfer(b, 3, 1'b0);
      begin
        wait (pn === 1'b0);
        repeat (18) @(posedge clk);
        chk(oe === 1'b0, "output enable while paused");
        wb(0, fph_pkg::ADDR_LINK, 32'h0, q);
        chk(q[2] === 1'b1 && q[6:4] === 3'h4, "paused at bit four");
      end
    join
    wb(0, fph_pkg::ADDR_LINK, 32'h0, q);
    chk(q[15:8] === b, "received byte");
    chk(rxo === 8'(1 << fph_pkg::SR_LATCH), "status shifted out");
    s0 = starts;
    wb(1, fph_pkg::ADDR_TARGET, 32'h0, q);
    wb(1, fph_pkg::ADDR_CMD, {29'h0, fph_pkg::OP_SE}, q);
    fph_spi_master_i.xfer(b, 2, 1'b1);
    wb(0, fph_pkg::ADDR_LINK, 32'h0, q);
    chk(q[3] === 1'b0 && q[6:4] === 3'h0, "deselect in pause");
    wait_idle();
    chk(starts - s0 == 1 && c_span === fph_pkg::SPAN_SECT, "erase through pause");
    $display("Pause test done");
    summarize();
  end
endmodule // fph_top_tb
`default_nettype wire
